// ===== dumsig_asserts.sv
// Purpose: Checker on the modem-signal block top ports
// Assumes: One clock, srst synchronous active high
// Notes:   Shadows control writes to predict pin levels
module dumsig_asserts (
  input wire logic                          clk_sys,
  input wire logic                          srst,
  input wire logic                          platform_bus_reset_n,
  input wire logic [dumsig_pkg::ADDR_W-1:0] avs_address,
  input wire logic                          avs_read,
  input wire logic                          avs_write,
  input wire logic [dumsig_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0]                    avs_byteenable,
  input wire logic                          avs_waitrequest,
  input wire logic                          port0_serial_out,
  input wire logic                          port1_serial_out,
  input wire logic [1:0]                    clear_send_n,
  input wire logic [1:0]                    set_ready_n,
  input wire logic [1:0]                    carrier_detect_n,
  input wire logic [1:0]                    ring_indicate_n,
  input wire logic [1:0]                    term_ready_n,
  input wire logic [1:0]                    term_ready_oe,
  input wire logic [1:0]                    req_send_n,
  input wire logic [1:0]                    modem_irq
);
  import dumsig_pkg::*;
  logic [4:0] ctl0_q, ctl1_q;
  logic [3:0] quiet_q, pins_q, pins0;
  logic       hit_q, ack, hit0;
  assign ack = !avs_waitrequest;
  // Accesses that may legally drop the port 0 request
  assign hit0 = ack && (avs_read && avs_address == OFS_STATUS ||
                avs_write && avs_address == OFS_CONTROL);
  assign pins0 = {clear_send_n[0], set_ready_n[0], carrier_detect_n[0],
                  ring_indicate_n[0]};
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl0_q <= 5'h00;
      ctl1_q <= 5'h00;
    end else if (ack && avs_write && avs_byteenable[0]) begin
      if (avs_address == OFS_CONTROL) ctl0_q <= avs_writedata[4:0];
      if (avs_address == PORT_STRIDE) ctl1_q <= avs_writedata[4:0];
    end
  end
  always_ff @(posedge clk_sys) begin
    hit_q  <= hit0;
    pins_q <= pins0;
    if (srst || pins_q != pins0) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_RST_OUT: assert property ($fell(srst) |->
    term_ready_n == 2'b11 &&
    req_send_n == 2'b11 && modem_irq == 2'b00 && port0_serial_out &&
    port1_serial_out) else $error("outputs not idle after reset");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_ACK_NEXT: assert property ($rose(avs_read || avs_write) |=>
    !avs_waitrequest) else $error("bus answer late");
  AST_IRQ_CHG: assert property (ctl0_q[MCR_IRQ_EN] &&
    pins_q[3:1] != pins0[3:1] |-> ##[1:6] modem_irq[0])
    else $error("no interrupt after modem input change");
  AST_HOLD: assert property (modem_irq[0] && !hit0 && !hit_q |=>
    modem_irq[0]) else $error("interrupt dropped on its own");
  AST_CLR: assert property (hit0 && avs_read && quiet_q > 4'h8
    |-> ##[1:2] !modem_irq[0]) else $error("status read left request");
  AST_RTS: assert property (ctl0_q == $past(ctl0_q, 2) |->
    req_send_n[0] == !(ctl0_q[MCR_REQ_SEND] && !ctl0_q[MCR_LOOPBACK]))
    else $error("request-send pin mismatch");
  AST_DTR1: assert property (ctl1_q == $past(ctl1_q, 2) |->
    term_ready_n[1] == !(ctl1_q[MCR_TERM_READY] && !ctl1_q[MCR_LOOPBACK]))
    else $error("terminal-ready pin mismatch");
  AST_STRAP_OE: assert property (!platform_bus_reset_n [*4] |->
    !term_ready_oe[0]) else $error("strap pin driven in bus reset");
endmodule : dumsig_asserts
bind dumsig_top dumsig_asserts u_asserts (.clk_sys(clk_sys), .srst(srst),
  .platform_bus_reset_n(platform_bus_reset_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .port0_serial_out(port0_serial_out), .port1_serial_out(port1_serial_out),
  .clear_send_n(clear_send_n), .set_ready_n(set_ready_n),
  .carrier_detect_n(carrier_detect_n), .ring_indicate_n(ring_indicate_n),
  .term_ready_n(term_ready_n), .term_ready_oe(term_ready_oe),
  .req_send_n(req_send_n), .modem_irq(modem_irq));

// ===== dumsig_modem.sv
// Purpose: Modem model facing both serial ports
// Assumes: Bit period of BIT_CYC clocks, 8N1 frames
// Notes:   Receive line held at mark; only bench-set pin levels sent
module dumsig_modem #(
  parameter int unsigned BIT_CYC = 22
) (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  want_n,
  input  wire logic [1:0]  serial_out,
  output logic      [1:0]  serial_in,
  output logic      [1:0]  clear_send_n,
  output logic      [1:0]  set_ready_n,
  output logic      [1:0]  ring_indicate_n,
  output logic      [1:0]  carrier_detect_n,
  output logic      [15:0] rx_data,
  output logic      [15:0] rx_count
);
  timeunit 1ns;
  timeprecision 100ps;
  assign serial_in = 2'b11;
  // Pin index p*4+k: clear-send, set-ready, ring, carrier
  always_ff @(posedge clk_sys) begin
    clear_send_n     <= {want_n[4], want_n[0]};
    set_ready_n      <= {want_n[5], want_n[1]};
    ring_indicate_n  <= {want_n[6], want_n[2]};
    carrier_detect_n <= {want_n[7], want_n[3]};
  end
  ////////////////////////////////////////////////////////////
  task automatic rx(input int p);
    logic [7:0] b;
    forever begin
      @(negedge serial_out[p]);
      repeat (BIT_CYC / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk_sys);
        b[i] = serial_out[p];
      end
      repeat (BIT_CYC) @(posedge clk_sys);
      // Bad stop bit leaves the count unchanged
      if (serial_out[p] === 1'b1) begin
        rx_data[p*8+:8] = b;
        rx_count[p*8+:8] = rx_count[p*8+:8] + 8'h01;
      end
    end
  endtask : rx
  initial begin
    rx_data = 16'h0000;
    rx_count = 16'h0000;
    fork
      rx(0);
      rx(1);
    join
  end
endmodule : dumsig_modem

// ===== dumsig_pkg.sv
// Purpose: Shared constants for the dual serial port modem-signal block
// Assumes: Avalon-MM, 32-bit data, word addressed by byte offset
// Notes:   Register map is a per-port window of four words
package dumsig_pkg;

  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned NUM_PORTS     = 2;

  // Byte offsets inside one port window; port 1 adds PORT_STRIDE; OFS_STRAP is one shared word after both windows
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_TX_DATA    = 8'h08;
  localparam logic [7:0] OFS_BAUD_DIV   = 8'h0c;
  localparam logic [7:0] PORT_STRIDE    = 8'h10;
  localparam logic [7:0] OFS_STRAP      = 8'h20;

  // Modem control register fields
  localparam int unsigned MCR_TERM_READY = 0;
  localparam int unsigned MCR_REQ_SEND   = 1;
  localparam int unsigned MCR_IRQ_EN     = 3;
  localparam int unsigned MCR_LOOPBACK   = 4;

  // Modem line status register fields
  localparam int unsigned MSR_CTS_CHG    = 0;
  localparam int unsigned MSR_DSR_CHG    = 1;
  localparam int unsigned MSR_RING_TRAIL = 2;
  localparam int unsigned MSR_DCD_CHG    = 3;
  localparam int unsigned MSR_CTS        = 4;
  localparam int unsigned MSR_DSR        = 5;
  localparam int unsigned MSR_RING       = 6;
  localparam int unsigned MSR_DCD        = 7;

  localparam logic [7:0]  MCR_RESET      = 8'h00;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0015;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
  localparam int unsigned TX_FRAME_BITS  = 10;

  typedef enum logic [1:0] {
    DUMSIG_TX_IDLE,
    DUMSIG_TX_SHIFT
  } dumsig_tx_state_t;

endpackage : dumsig_pkg

// ===== dumsig_sync2.sv
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Input level may change at any time
// Notes:   Reset value is the inactive (high) level
module dumsig_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : dumsig_sync2

// ===== dumsig_top.sv
// Purpose: Two serial ports: transmit line, modem status and control pins
// Assumes: Avalon-MM slave on clk_sys; modem inputs are asynchronous pins
// Notes:   Receive path is only synchronised and exposed in status
//          Bus-reset and power-good flops reset low: bus reset asserted, power not good
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
module dumsig_top
  import dumsig_pkg::*;
(
  input  wire logic                      clk_sys,
  input  wire logic                      srst,
  input  wire logic                      platform_bus_reset_n,
  input  wire logic                      power_good,
  input  wire logic [dumsig_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [dumsig_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [dumsig_pkg::DATA_W-1:0] avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      port0_serial_in,
  input  wire logic                      port1_serial_in,
  output logic                           port0_serial_out,
  output logic                           port1_serial_out,
  input  wire logic [1:0]                clear_send_n,
  input  wire logic [1:0]                set_ready_n,
  input  wire logic [1:0]                carrier_detect_n,
  input  wire logic [1:0]                ring_indicate_n,
  output logic      [1:0]                term_ready_n,
  output logic      [1:0]                term_ready_oe,
  output logic      [1:0]                req_send_n,
  output logic      [1:0]                modem_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [1:0] cts_s, dsr_s, dcd_s, ri_s, rx_s;
  logic [1:0] ctl_meta_q;
  logic [1:0] ctl_sync_q;

  dumsig_sync2 #(.WIDTH(10)) u_sync_modem (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in ({clear_send_n, set_ready_n, carrier_detect_n,
                ring_indicate_n, port1_serial_in, port0_serial_in}),
    .sync_out ({cts_s, dsr_s, dcd_s, ri_s, rx_s})
  );

  // [1] bus reset released, [0] power good; both reset low so that
  // srst neither releases the strap pin nor fakes a power-good edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl_meta_q <= 2'b00;
      ctl_sync_q <= 2'b00;
    end else begin
      ctl_meta_q <= {platform_bus_reset_n, power_good};
      ctl_sync_q <= ctl_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [2:0] dec_reg(input logic [7:0] addr);
    // [2] = port, [1:0] = register within window
    return {addr[4], addr[3:2]};
  endfunction : dec_reg

  logic       is_port_win;
  logic       is_strap;
  logic [2:0] dec;
  logic       bus_req;

  assign is_port_win = (avs_address < OFS_STRAP) &&
                       (avs_address[1:0] == 2'b00);
  assign is_strap    = (avs_address == OFS_STRAP);
  assign dec         = dec_reg(avs_address);

  // One wait cycle per access: request taken when waitrequest drops
  logic ack_q;
  assign bus_req = (avs_read || avs_write) && !ack_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !bus_req;
    end
  end

  logic do_wr, do_rd, rd_take;
  assign do_wr = ack_q && avs_write;
  assign do_rd = ack_q && avs_read;
  // Flags clear at the edge that loads readdata, never one later:
  // a change landing in between would otherwise be lost unreported
  assign rd_take = bus_req && avs_read;

  ////////////////////////////////////////////////////////////////////////
  // Strap capture and port 0 terminal-ready release

  logic pg_prev_q, strap_q, drive_en_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pg_prev_q <= 1'b0;
      strap_q   <= 1'b1;
    end else begin
      pg_prev_q <= ctl_sync_q[0];
      if (ctl_sync_q[0] && !pg_prev_q) begin
        strap_q <= dsr_s[0] | 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || !ctl_sync_q[1]) begin
      drive_en_q <= 1'b0;
    end else begin
      drive_en_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-port registers and status

  logic [7:0]  mcr_q   [NUM_PORTS];
  logic [15:0] baud_q  [NUM_PORTS];
  logic [3:0]  chg_q   [NUM_PORTS];
  logic [7:0]  modem_line_status     [NUM_PORTS];
  logic [1:0]  tx_busy;
  logic [1:0]  tx_line;
  logic [1:0]  tx_load;
  logic [31:0] rd_port [NUM_PORTS];

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
      logic [3:0] lvl_q;
      logic [3:0] lvl;
      logic       sel;
      logic       rd_msr;

      assign sel    = is_port_win && (dec[2] == 1'(gp));
      assign rd_msr = rd_take && sel &&
                      (dec[1:0] == OFS_STATUS[3:2]);
      // Status bits are the complements of the active-low pins
      assign lvl    = {~dcd_s[gp], ~ri_s[gp], ~dsr_s[gp], ~cts_s[gp]};
      assign modem_line_status[gp] = {lvl, chg_q[gp]};

      always_ff @(posedge clk_sys) begin
        if (srst) begin
          lvl_q <= 4'h0;
        end else begin
          lvl_q <= lvl;
        end
      end

      // Set wins over the clear of the same read
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          chg_q[gp] <= 4'h0;
        end else begin
          chg_q[gp][MSR_CTS_CHG] <= (lvl[0] != lvl_q[0]) ||
              (chg_q[gp][MSR_CTS_CHG] && !rd_msr);
          chg_q[gp][MSR_DSR_CHG] <= (lvl[1] != lvl_q[1]) ||
              (chg_q[gp][MSR_DSR_CHG] && !rd_msr);
          chg_q[gp][MSR_RING_TRAIL] <= (!lvl[2] && lvl_q[2]) ||
              (chg_q[gp][MSR_RING_TRAIL] && !rd_msr);
          chg_q[gp][MSR_DCD_CHG] <= (lvl[3] != lvl_q[3]) ||
              (chg_q[gp][MSR_DCD_CHG] && !rd_msr);
        end
      end

      always_ff @(posedge clk_sys) begin
        if (srst) begin
          mcr_q[gp]  <= MCR_RESET;
          baud_q[gp] <= BAUD_DIV_RESET;
        end else if (do_wr && sel && avs_byteenable[0]) begin
          if (dec[1:0] == OFS_CONTROL[3:2]) begin
            mcr_q[gp] <= avs_writedata[7:0];
          end
          if (dec[1:0] == OFS_BAUD_DIV[3:2] && avs_byteenable[1]) begin
            baud_q[gp] <= avs_writedata[15:0];
          end
        end
      end

      assign tx_load[gp] = do_wr && sel && avs_byteenable[0] &&
                           (dec[1:0] == OFS_TX_DATA[3:2]) && !tx_busy[gp];

      // Transmitter sees no modem status input
      dumsig_tx u_tx (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .baud_div   (baud_q[gp]),
        .load       (tx_load[gp]),
        .load_data  (avs_writedata[7:0]),
        .busy       (tx_busy[gp]),
        .serial_out (tx_line[gp])
      );

      always_ff @(posedge clk_sys) begin
        if (srst) begin
          term_ready_n[gp] <= 1'b1;
          req_send_n[gp]   <= 1'b1;
        end else if (mcr_q[gp][MCR_LOOPBACK]) begin
          term_ready_n[gp] <= 1'b1;
          req_send_n[gp]   <= 1'b1;
        end else begin
          term_ready_n[gp] <= ~mcr_q[gp][MCR_TERM_READY];
          req_send_n[gp]   <= ~mcr_q[gp][MCR_REQ_SEND];
        end
      end

      always_ff @(posedge clk_sys) begin
        if (srst) begin
          modem_irq[gp] <= 1'b0;
        end else begin
          modem_irq[gp] <= mcr_q[gp][MCR_IRQ_EN] && (|chg_q[gp]);
        end
      end

      assign rd_port[gp] = (dec[1:0] == OFS_CONTROL[3:2]) ?
                             {24'h000000, mcr_q[gp]} :
                           (dec[1:0] == OFS_STATUS[3:2]) ?
                             {22'h0, rx_s[gp], tx_busy[gp], modem_line_status[gp]} :
                           (dec[1:0] == OFS_BAUD_DIV[3:2]) ?
                             {16'h0000, baud_q[gp]} :
                             {31'h0, tx_busy[gp]};
    end
  endgenerate

  // Port 0 strap pin released only once the bus reset has gone
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      term_ready_oe <= 2'b10;
    end else begin
      term_ready_oe <= {1'b1, drive_en_q};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      port0_serial_out <= 1'b1;
      port1_serial_out <= 1'b1;
    end else begin
      port0_serial_out <= tx_line[0];
      port1_serial_out <= tx_line[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_readdata <= UNMAPPED_DATA;
    end else if (bus_req && avs_read) begin
      if (is_port_win) begin
        avs_readdata <= rd_port[dec[2]];
      end else if (is_strap) begin
        avs_readdata <= {31'h0, strap_q};
      end else begin
        avs_readdata <= UNMAPPED_DATA;
      end
    end
  end

endmodule : dumsig_top

// ===== dumsig_top_tb.sv
// Purpose: Self-checking bench for the modem-signal block
// Assumes: Avalon-MM master tasks, modem model on the pins
// Notes:   Default baud divisor kept; frames are short
module dumsig_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dumsig_pkg::*;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        platform_bus_reset_n = 1'b0;
  logic        power_good = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata, q;
  logic        avs_waitrequest;
  logic [1:0]  serial_in, clear_send_n, set_ready_n, carrier_detect_n;
  logic [1:0]  ring_indicate_n, term_ready_n, term_ready_oe, req_send_n;
  logic [1:0]  modem_irq, serial_out;
  logic [7:0]  want_n = 8'hff;
  logic [15:0] rx_data, rx_count;
  int          errors = 0;
  int          cmp_count = 0;
  localparam logic [7:0] CTLV [5] = '{8'h01, 8'h02, 8'h03, 8'h13, 8'h00};
  dumsig_top dut (.clk_sys(clk_sys), .srst(srst),
    .platform_bus_reset_n(platform_bus_reset_n), .power_good(power_good),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port0_serial_in(serial_in[0]), .port1_serial_in(serial_in[1]),
    .port0_serial_out(serial_out[0]), .port1_serial_out(serial_out[1]),
    .clear_send_n(clear_send_n), .set_ready_n(set_ready_n),
    .carrier_detect_n(carrier_detect_n), .ring_indicate_n(ring_indicate_n),
    .term_ready_n(term_ready_n), .term_ready_oe(term_ready_oe),
    .req_send_n(req_send_n), .modem_irq(modem_irq));
  dumsig_modem u_modem (.clk_sys(clk_sys), .want_n(want_n),
    .serial_out(serial_out), .serial_in(serial_in),
    .clear_send_n(clear_send_n), .set_ready_n(set_ready_n),
    .ring_indicate_n(ring_indicate_n), .carrier_detect_n(carrier_detect_n),
    .rx_data(rx_data), .rx_count(rx_count));
  initial forever #12.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_write <= w;
    avs_read <= !w;
    // Wait as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  initial begin
    #(25 * 20000);
    errors++;
    $display("Error at %0t ns: watchdog expired", $time);
    end_of_test();
  end
  initial begin
    logic [7:0]  base;
    logic [31:0] live;
    logic        en;
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    power_good <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(term_ready_oe, 2'b10);
    chk({serial_out, term_ready_n, req_send_n}, 6'h3f);
    platform_bus_reset_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(term_ready_oe, 2'b11);
    rd(OFS_STRAP, 32'h1);
    rd(OFS_CONTROL, {24'h0, MCR_RESET});
    rd(OFS_BAUD_DIV, {16'h0, BAUD_DIV_RESET});
    acc(1'b1, 8'h30, 32'hffff_ffff);
    rd(8'h30, UNMAPPED_DATA);
    acc(1'b1, OFS_CONTROL, 32'h8);
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 4; k++) begin
        base = 8'(p * 16);
        en = (p == 0);
        live = 32'h200 | (32'h1 << (4 + k));
        rd(base + OFS_STATUS, 32'h200);
        want_n[p*4+k] <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk(modem_irq[p], en && k != 2);
        live = live | (k != 2 ? 32'h1 << k : 32'h0);
        rd(base + OFS_STATUS, live);
        rd(base + OFS_STATUS, live & ~32'hf);
        chk(modem_irq[p], 1'b0);
        want_n[p*4+k] <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk(modem_irq[p], en);
        rd(base + OFS_STATUS, 32'h200 | (32'h1 << k));
      end
    end
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 5; i++) begin
        base = 8'(p * 16);
        acc(1'b1, base, {24'h0, CTLV[i]});
        repeat (4) @(posedge clk_sys);
        chk({term_ready_n[p], req_send_n[p]},
            {!(CTLV[i][0] && !CTLV[i][4]), !(CTLV[i][1] && !CTLV[i][4])});
        rd(base, {24'h0, CTLV[i]});
      end
    end
    // Clear-send and set-ready stay inactive: sending must still go ahead
    acc(1'b1, OFS_TX_DATA, 32'ha5);
    acc(1'b1, OFS_TX_DATA, 32'h5a);
    acc(1'b1, PORT_STRIDE + OFS_TX_DATA, 32'h3c);
    rd(OFS_STATUS, 32'h300);
    repeat (300) @(posedge clk_sys);
    chk({rx_count, rx_data}, 32'h0101_3ca5);
    acc(1'b1, OFS_CONTROL, 32'h3);
    srst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({serial_out, term_ready_n, req_send_n}, 6'h3f);
    rd(OFS_CONTROL, {24'h0, MCR_RESET});
    end_of_test();
  end
endmodule : dumsig_top_tb

// ===== dumsig_tx.sv
// Purpose: One serial port transmitter, 8N1, plus its baud generator
// Assumes: Baud enable derived from the single reference clock
// Notes:   Modem status inputs never reach this module
module dumsig_tx
  import dumsig_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic [15:0] baud_div,
  input  wire logic        load,
  input  wire logic [7:0]  load_data,
  output logic             busy,
  output logic             serial_out
);

  logic [15:0]      div_cnt_q;
  logic             bit_tick;
  logic [9:0]       shift_q;
  logic [3:0]       bits_left_q;
  dumsig_tx_state_t state_q;

  // Bit-rate enable from the reference clock
  always_ff @(posedge clk_sys) begin
    if (srst || state_q == DUMSIG_TX_IDLE) begin
      div_cnt_q <= 16'h0000;
      bit_tick  <= 1'b0;
    end else if (div_cnt_q >= baud_div) begin
      div_cnt_q <= 16'h0000;
      bit_tick  <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
      bit_tick  <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q     <= DUMSIG_TX_IDLE;
      shift_q     <= 10'h3ff;
      bits_left_q <= 4'h0;
      serial_out  <= 1'b1;
    end else begin
      case (state_q)
        DUMSIG_TX_IDLE: begin
          serial_out <= 1'b1;
          if (load) begin
            shift_q     <= {1'b1, load_data, 1'b0};
            bits_left_q <= 4'(TX_FRAME_BITS);
            state_q     <= DUMSIG_TX_SHIFT;
          end
        end
        DUMSIG_TX_SHIFT: begin
          serial_out <= shift_q[0];
          if (bit_tick) begin
            shift_q     <= {1'b1, shift_q[9:1]};
            bits_left_q <= bits_left_q - 4'h1;
            if (bits_left_q == 4'h1) begin
              state_q <= DUMSIG_TX_IDLE;
            end
          end
        end
        default: begin
          state_q <= DUMSIG_TX_IDLE;
        end
      endcase
    end
  end

  assign busy = (state_q != DUMSIG_TX_IDLE);

endmodule : dumsig_tx
